/* File: logic/gpo_consts.svh */
`ifndef GPO_CONSTS_SVH
`define GPO_CONSTS_SVH

`define GPO_OFS_DIR 8'h00
`define GPO_OFS_LATCH 8'h04
`define GPO_OFS_PIN 8'h08
`define GPO_OFS_CTRL 8'h0C
`define GPO_OFS_SENSE 8'h10
`define GPO_OFS_STATUS 8'h14
`define GPO_OFS_MASK 8'h18

`define GPO_CTRL_GPOFF_BIT 0
`define GPO_RST_WORD 32'h0000_0000
`define GPO_RST_BIT 1'b0

`define GPO_SENSE_LOW 2'h0
`define GPO_SENSE_ANY 2'h1
`define GPO_SENSE_FALL 2'h2
`define GPO_SENSE_RISE 2'h3

`define GPO_RESP_OKAY 2'h0
`define GPO_RESP_SLVERR 2'h2

`define GPO_CLK_PERIOD_NS 100
`define GPO_READBACK_NS 100
`define GPO_READBACK_CYC ((`GPO_READBACK_NS + `GPO_CLK_PERIOD_NS - 1) / `GPO_CLK_PERIOD_NS)

`define GPO_MAX_WIDTH 16

`endif

/* File: logic/gpo_pkg.sv */
package gpo_pkg;

	// Override controls from one alternate-function peripheral for one pin
	typedef struct packed {
		logic pullup_override_enable;
		logic pullup_override_value;
		logic direction_override_enable;
		logic direction_override_value;
		logic outvalue_override_enable;
		logic outvalue_override_value;
		logic toggle_override_enable;
		logic input_enable_override_enable;
		logic input_enable_override_value;
	} gpo_ovr_t;

	typedef enum logic [2:0] {
		GPO_SLP_ACTIVE = 3'h0,
		GPO_SLP_IDLE = 3'h1,
		GPO_SLP_ADC_QUIET = 3'h2,
		GPO_SLP_PWR_DOWN = 3'h3,
		GPO_SLP_PWR_SAVE = 3'h4,
		GPO_SLP_STANDBY = 3'h5,
		GPO_SLP_EXT_STANDBY = 3'h6
	} gpo_sleep_t;

endpackage

/* File: logic/gpo_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpo_consts.svh"

module gpo_port #(
	parameter int WIDTH = 8,
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [WIDTH-1:0] pad_in,
	output logic [WIDTH-1:0] pad_out,
	output logic [WIDTH-1:0] pad_oe_n,
	output logic [WIDTH-1:0] pullup_en,
	input wire gpo_pkg::gpo_ovr_t [WIDTH-1:0] ovr,
	input wire gpo_pkg::gpo_sleep_t sleep_mode,
	input wire logic [WIDTH-1:0] analog_drive,
	input wire logic [WIDTH-1:0] analog_drive_en,
	output logic [WIDTH-1:0] alt_func_input_tap,
	output logic [WIDTH-1:0] pad_analog_link,
	output logic irq
);

	if (WIDTH < 1 || WIDTH > `GPO_MAX_WIDTH) begin : g_bad_width
		$error("gpo_port: WIDTH must be 1 to 16");
	end
	if (ADDR_W < 5) begin : g_bad_addr
		$error("gpo_port: ADDR_W too small for the register map");
	end

	typedef struct packed {
		logic [WIDTH-1:0] direction_bit;
		logic [WIDTH-1:0] drive_latch_bit;
		logic [WIDTH-1:0] pin_sample_bit;
		logic [WIDTH-1:0] sample_prev;
		logic [WIDTH-1:0] status;
		logic [WIDTH-1:0] mask;
		logic [2*WIDTH-1:0] sense;
		logic global_pullup_off;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gpo_state_t;

	gpo_state_t state_ff;
	gpo_state_t nxt_state;
	logic [WIDTH-1:0] sync_latch_ff;

	logic [WIDTH-1:0] pue_v, puv_v, doe_v, dov_v, ov_en_v, ov_val_v, tog_v, ie_en_v, diev_v;
	logic [WIDTH-1:0] in_enable;
	logic [WIDTH-1:0] drv_enable;
	logic [WIDTH-1:0] pu_normal;
	logic [WIDTH-1:0] evt;
	logic [WIDTH-1:0] status_clr;
	logic [WIDTH-1:0] wr_ones;
	logic [31:0] wr_merged;
	logic [31:0] rd_word;
	logic clamp_mode;
	logic wr_go;
	logic rd_go;

	// Byte-lane merge of a write into an existing word
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Register word as software sees it; unmapped offsets read zero
	function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a,
			input gpo_state_t s);
		logic [31:0] w;
		w = `GPO_RST_WORD;
		unique case (a)
			ADDR_W'(`GPO_OFS_DIR): w[WIDTH-1:0] = s.direction_bit;
			ADDR_W'(`GPO_OFS_LATCH): w[WIDTH-1:0] = s.drive_latch_bit;
			ADDR_W'(`GPO_OFS_PIN): w[WIDTH-1:0] = s.pin_sample_bit;
			ADDR_W'(`GPO_OFS_CTRL): w[`GPO_CTRL_GPOFF_BIT] = s.global_pullup_off;
			ADDR_W'(`GPO_OFS_SENSE): w[2*WIDTH-1:0] = s.sense;
			ADDR_W'(`GPO_OFS_STATUS): w[WIDTH-1:0] = s.status;
			ADDR_W'(`GPO_OFS_MASK): w[WIDTH-1:0] = s.mask;
			default: w = `GPO_RST_WORD;
		endcase
		return w;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return a == ADDR_W'(`GPO_OFS_DIR) || a == ADDR_W'(`GPO_OFS_LATCH) ||
			a == ADDR_W'(`GPO_OFS_PIN) || a == ADDR_W'(`GPO_OFS_CTRL) ||
			a == ADDR_W'(`GPO_OFS_SENSE) || a == ADDR_W'(`GPO_OFS_STATUS) ||
			a == ADDR_W'(`GPO_OFS_MASK);
	endfunction

	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			pue_v[i] = ovr[i].pullup_override_enable;
			puv_v[i] = ovr[i].pullup_override_value;
			doe_v[i] = ovr[i].direction_override_enable;
			dov_v[i] = ovr[i].direction_override_value;
			ov_en_v[i] = ovr[i].outvalue_override_enable;
			ov_val_v[i] = ovr[i].outvalue_override_value;
			tog_v[i] = ovr[i].toggle_override_enable;
			ie_en_v[i] = ovr[i].input_enable_override_enable;
			diev_v[i] = ovr[i].input_enable_override_value;
		end
	end

	// Deep sleep modes except extended standby clamp floating inputs to save power
	assign clamp_mode = sleep_mode == gpo_pkg::GPO_SLP_PWR_DOWN ||
		sleep_mode == gpo_pkg::GPO_SLP_PWR_SAVE ||
		sleep_mode == gpo_pkg::GPO_SLP_STANDBY;
	// Pins enabled as external interrupts stay live to wake the device
	assign in_enable = (ie_en_v & diev_v) |
		(~ie_en_v & ~({WIDTH{clamp_mode}} & ~state_ff.mask));
	assign alt_func_input_tap = pad_in & in_enable;
	assign pad_analog_link = pad_in;

	assign drv_enable = analog_drive_en |
		(doe_v & dov_v) | (~doe_v & state_ff.direction_bit);
	assign pad_oe_n = ~(drv_enable & {WIDTH{aresetn}});
	assign pad_out = (analog_drive_en & analog_drive) |
		(~analog_drive_en & ov_en_v & ov_val_v) |
		(~analog_drive_en & ~ov_en_v & state_ff.drive_latch_bit);
	assign pu_normal = ~state_ff.direction_bit & state_ff.drive_latch_bit &
		~{WIDTH{state_ff.global_pullup_off}};
	assign pullup_en = ((pue_v & puv_v) | (~pue_v & pu_normal)) &
		{WIDTH{aresetn}};

	assign irq = |(state_ff.status & state_ff.mask);

	assign wr_go = clk_en & s_axi_awvalid & s_axi_wvalid & ~state_ff.bvalid;
	assign rd_go = clk_en & s_axi_arvalid & ~state_ff.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = state_ff.bvalid;
	assign s_axi_bresp = state_ff.bresp;
	assign s_axi_rvalid = state_ff.rvalid;
	assign s_axi_rdata = state_ff.rdata;
	assign s_axi_rresp = state_ff.rresp;

	// A clamp-to-low during sleep makes a high rise- or any-edge-sensed pin look like an edge on wake
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			unique case (state_ff.sense[2*i +: 2])
				`GPO_SENSE_LOW: evt[i] = ~state_ff.pin_sample_bit[i];
				`GPO_SENSE_ANY: evt[i] = state_ff.pin_sample_bit[i] ^ state_ff.sample_prev[i];
				`GPO_SENSE_FALL: evt[i] = ~state_ff.pin_sample_bit[i] & state_ff.sample_prev[i];
				`GPO_SENSE_RISE: evt[i] = state_ff.pin_sample_bit[i] & ~state_ff.sample_prev[i];
			endcase
		end
	end

	always_comb begin
		nxt_state = state_ff;
		status_clr = '0;
		wr_merged = strb_merge(reg_word(s_axi_awaddr, state_ff), s_axi_wdata, s_axi_wstrb);
		rd_word = strb_merge(`GPO_RST_WORD, s_axi_wdata, s_axi_wstrb);
		wr_ones = rd_word[WIDTH-1:0];
		rd_word = reg_word(s_axi_araddr, state_ff);
		if (clk_en) begin
			nxt_state.sample_prev = state_ff.pin_sample_bit;
			nxt_state.pin_sample_bit = sync_latch_ff;
			nxt_state.drive_latch_bit = state_ff.drive_latch_bit ^ tog_v;
			if (state_ff.bvalid && s_axi_bready) begin
				nxt_state.bvalid = 1'b0;
			end
			if (state_ff.rvalid && s_axi_rready) begin
				nxt_state.rvalid = 1'b0;
			end
			if (wr_go) begin
				nxt_state.bvalid = 1'b1;
				nxt_state.bresp = addr_hit(s_axi_awaddr) ? `GPO_RESP_OKAY : `GPO_RESP_SLVERR;
				unique case (s_axi_awaddr)
					ADDR_W'(`GPO_OFS_DIR): nxt_state.direction_bit = wr_merged[WIDTH-1:0];
					ADDR_W'(`GPO_OFS_LATCH): begin
						nxt_state.drive_latch_bit = wr_merged[WIDTH-1:0] ^ tog_v;
					end
					ADDR_W'(`GPO_OFS_PIN): begin
						nxt_state.drive_latch_bit = state_ff.drive_latch_bit ^ tog_v ^
							wr_ones;
					end
					ADDR_W'(`GPO_OFS_CTRL): begin
						nxt_state.global_pullup_off = wr_merged[`GPO_CTRL_GPOFF_BIT];
					end
					ADDR_W'(`GPO_OFS_SENSE): nxt_state.sense = wr_merged[2*WIDTH-1:0];
					ADDR_W'(`GPO_OFS_STATUS): status_clr = wr_ones;
					ADDR_W'(`GPO_OFS_MASK): nxt_state.mask = wr_merged[WIDTH-1:0];
					default: nxt_state.bresp = `GPO_RESP_SLVERR;
				endcase
			end
			// Set beats clear so no event is lost in the clearing cycle
			nxt_state.status = (state_ff.status & ~status_clr) | evt;
			if (rd_go) begin
				nxt_state.rvalid = 1'b1;
				nxt_state.rdata = rd_word;
				nxt_state.rresp = addr_hit(s_axi_araddr) ? `GPO_RESP_OKAY : `GPO_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Falling-edge capture stands in for the latch that closes while the clock is low
	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			sync_latch_ff <= '0;
		end else if (clk_en) begin
			sync_latch_ff <= alt_func_input_tap;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pin_read;
		rd_go && s_axi_araddr == ADDR_W'(`GPO_OFS_PIN) ##1 s_axi_rvalid;
	endsequence

	sequence s_pin_toggle_write;
		wr_go && s_axi_awaddr == ADDR_W'(`GPO_OFS_PIN) && s_axi_wstrb[0] &&
			tog_v == '0;
	endsequence

	property p_sample_path;
		clk_en |=> state_ff.pin_sample_bit == $past(sync_latch_ff);
	endproperty
	a_sample_path: assert property (p_sample_path) else $error("sample bit missed latch");

	property p_pin_read;
		s_pin_read |-> s_axi_rdata[WIDTH-1:0] == $past(state_ff.pin_sample_bit);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin read wrong value");

	property p_clamp;
		clamp_mode && ie_en_v[0] == 1'b0 && !state_ff.mask[0] |-> !alt_func_input_tap[0];
	endproperty
	a_clamp: assert property (p_clamp) else $error("input not clamped in sleep");

	property p_bypass;
		state_ff.mask[0] && !ie_en_v[0] |-> alt_func_input_tap[0] == pad_in[0];
	endproperty
	a_bypass: assert property (p_bypass) else $error("interrupt pin clamped");

	property p_reset_pullup;
		// Must stay armed while reset is low, so the default disable is overridden
		@(posedge aclk) disable iff (1'b0) !aresetn |-> pullup_en == '0 && pad_oe_n == '1;
	endproperty
	a_reset_pullup: assert property (p_reset_pullup) else $error("pad not released in reset");

	property p_pullup_normal;
		!pue_v[0] |-> pullup_en[0] == (!state_ff.direction_bit[0] &&
			state_ff.drive_latch_bit[0] && !state_ff.global_pullup_off);
	endproperty
	a_pullup_normal: assert property (p_pullup_normal) else $error("pull-up wrong");

	property p_pullup_ovr;
		pue_v[0] |-> pullup_en[0] == puv_v[0];
	endproperty
	a_pullup_ovr: assert property (p_pullup_ovr) else $error("pull-up override ignored");

	property p_drive;
		!analog_drive_en[0] |-> !pad_oe_n[0] == (doe_v[0] ? dov_v[0] :
			state_ff.direction_bit[0]);
	endproperty
	a_drive: assert property (p_drive) else $error("driver enable wrong");

	property p_value;
		!analog_drive_en[0] |-> pad_out[0] == (ov_en_v[0] ? ov_val_v[0] :
			state_ff.drive_latch_bit[0]);
	endproperty
	a_value: assert property (p_value) else $error("driven value wrong");

	property p_toggle_ovr;
		clk_en && tog_v[0] && !wr_go |=> state_ff.drive_latch_bit[0] !=
			$past(state_ff.drive_latch_bit[0]);
	endproperty
	a_toggle_ovr: assert property (p_toggle_ovr) else $error("toggle override lost");

	property p_pin_toggle;
		s_pin_toggle_write |=> state_ff.drive_latch_bit[0] ==
			($past(state_ff.drive_latch_bit[0]) ^ $past(s_axi_wdata[0]));
	endproperty
	a_pin_toggle: assert property (p_pin_toggle) else $error("pin write toggle wrong");

	property p_event_flag;
		clk_en && evt != '0 |=> (state_ff.status & $past(evt)) == $past(evt);
	endproperty
	a_event_flag: assert property (p_event_flag) else $error("event flag lost");

	sequence s_latch_write;
		wr_go && s_axi_awaddr == ADDR_W'(`GPO_OFS_LATCH) && s_axi_wstrb[0] && tog_v == '0;
	endsequence

	property p_ie_ovr;
		ie_en_v[0] |-> alt_func_input_tap[0] == (diev_v[0] && pad_in[0]);
	endproperty
	a_ie_ovr: assert property (p_ie_ovr) else $error("input enable override ignored");

	property p_tap_live;
		!clamp_mode && !ie_en_v[0] |-> alt_func_input_tap[0] == pad_in[0];
	endproperty
	a_tap_live: assert property (p_tap_live) else $error("tap not following pad");

	property p_link;
		pad_analog_link == pad_in;
	endproperty
	a_link: assert property (p_link) else $error("analog link broken");

	property p_dir_out;
		!doe_v[0] && !analog_drive_en[0] && state_ff.direction_bit[0] |-> !pad_oe_n[0];
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("output pin not driven");

	property p_latch_write;
		s_latch_write |=> state_ff.drive_latch_bit[0] == $past(s_axi_wdata[0]);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost");

	property p_gpoff;
		state_ff.global_pullup_off && !pue_v[0] |-> !pullup_en[0];
	endproperty
	a_gpoff: assert property (p_gpoff) else $error("pull-up on while globally off");

	property p_freeze;
		!clk_en |=> state_ff == $past(state_ff);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	property p_write_answer;
		wr_go |=> s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write not answered");

	property p_read_answer;
		rd_go |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_bresp_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

	property p_rdata_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");

endmodule
`default_nettype wire

/* File: dv/gpo_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gpo_pad_model #(
	parameter int WIDTH = 8
) (
	input wire logic aclk,
	input wire logic [WIDTH-1:0] pad_out,
	input wire logic [WIDTH-1:0] pad_oe_n,
	input wire logic [WIDTH-1:0] pullup_en,
	input wire logic [WIDTH-1:0] ext_en,
	input wire logic [WIDTH-1:0] ext_val,
	output logic [WIDTH-1:0] pad_in
);
	// A released pad with no pull-up reads opposite to the last driven value
	logic [WIDTH-1:0] last_drv_ff = '0;
	always_ff @(posedge aclk) begin
		last_drv_ff <= pad_out;
	end
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (!pad_oe_n[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pullup_en[i]) begin
				pad_in[i] = 1'h1;
			end else begin
				pad_in[i] = ~last_drv_ff[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpo_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic clk_en = 1;
	logic [7:0] awaddr = '0, araddr = '0, ext_val = 8'hFF, adrv = '0, adrv_en = '0;
	logic [7:0] ext_en = 8'hFF;
	logic [31:0] wdata = '0, rdata, rd_q;
	gpo_pkg::gpo_ovr_t [7:0] ovr = '0;
	gpo_pkg::gpo_ovr_t [7:0] ovr_nx;
	gpo_pkg::gpo_sleep_t sleep_mode = gpo_pkg::GPO_SLP_ACTIVE;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, bresp_q, rresp_q;
	logic [7:0] pad_in, pad_out, pad_oe_n, pullup_en, tap, link, ex;
	int fails = 0, total_checks = 0;
	gpo_port dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
		.ovr(ovr), .sleep_mode(sleep_mode), .analog_drive(adrv), .analog_drive_en(adrv_en),
		.alt_func_input_tap(tap), .pad_analog_link(link), .irq(irq));
	gpo_pad_model pads (.aclk(aclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	initial begin
		forever #50 aclk = ~aclk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Ready is judged at the falling edge: inputs only move at rising edges
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_p, w_p, b_p, aw_h, w_h, b_h;
		aw_p = 1;
		w_p = 1;
		b_p = 1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (aw_p || w_p || b_p) begin
			@(negedge aclk);
			aw_h = aw_p && awready;
			w_h = w_p && wready;
			b_h = b_p && bvalid;
			if (b_h) bresp_q = bresp;
			@(posedge aclk);
			if (aw_h) begin
				awvalid <= 1'h0;
				aw_p = 0;
			end
			if (w_h) begin
				wvalid <= 1'h0;
				w_p = 0;
			end
			if (b_h) begin
				bready <= 1'h0;
				b_p = 0;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar_p, r_p, ar_h, r_h;
		ar_p = 1;
		r_p = 1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (ar_p || r_p) begin
			@(negedge aclk);
			ar_h = ar_p && arready;
			r_h = r_p && rvalid;
			if (r_h) begin
				rd_q = rdata;
				rresp_q = rresp;
			end
			@(posedge aclk);
			if (ar_h) begin
				arvalid <= 1'h0;
				ar_p = 0;
			end
			if (r_h) begin
				rready <= 1'h0;
				r_p = 0;
			end
		end
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`GPO_OFS_DIR);
		`CHK("dir_rst", 32'h0, rd_q)
		rd(`GPO_OFS_SENSE);
		`CHK("sense_rst", 32'h0, rd_q)
		rd(`GPO_OFS_MASK);
		`CHK("mask_rst", 32'h0, rd_q)
		// Wake from clamp on a high, rising-sensed, non-enabled pin
		wr(`GPO_OFS_SENSE, 32'h0000FFFF);
		wr(`GPO_OFS_STATUS, 32'h000000FF);
		rd(`GPO_OFS_STATUS);
		`CHK("status_quiet", 32'h0, rd_q)
		@(posedge aclk) sleep_mode <= gpo_pkg::GPO_SLP_PWR_DOWN;
		repeat (3) @(posedge aclk);
		sleep_mode <= gpo_pkg::GPO_SLP_ACTIVE;
		repeat (3) @(posedge aclk);
		rd(`GPO_OFS_STATUS);
		`CHK("wake_flag", 32'h000000FF, rd_q)
		`CHK("irq_masked", 1'h0, irq)
		wr(`GPO_OFS_MASK, 32'h1);
		`CHK("irq_on", 1'h1, irq)
		wr(`GPO_OFS_STATUS, 32'h1);
		rd(`GPO_OFS_STATUS);
		`CHK("status_w1c", 32'h000000FE, rd_q)
		`CHK("irq_off", 1'h0, irq)
		// Pin 0 is an enabled interrupt pin, pin 7 forces its input on
		@(posedge aclk) ovr[7].input_enable_override_enable <= 1'h1;
		ovr[7].input_enable_override_value <= 1'h1;
		for (int m = 0; m < 7; m++) begin
			@(posedge aclk) sleep_mode <= gpo_pkg::gpo_sleep_t'(m);
			@(negedge aclk);
			ex = (m == 3 || m == 4 || m == 5) ? 8'h81 : 8'hFF;
			`CHK("tap_sleep", ex, tap)
		end
		@(posedge aclk) sleep_mode <= gpo_pkg::GPO_SLP_ACTIVE;
		ovr[7].input_enable_override_value <= 1'h0;
		@(negedge aclk);
		`CHK("tap_ie_off", 8'h7F, tap)
		@(posedge aclk) ovr <= '0;
		ext_val <= 8'hF7;
		#1;
		`CHK("tap_unsync", 8'hF7, tap)
		`CHK("analog_link", 8'hF7, link)
		@(posedge aclk) ext_val <= 8'hFF;
		wr(`GPO_OFS_DIR, 32'h0F);
		wr(`GPO_OFS_LATCH, 32'h05);
		`CHK("oe_dir", 8'hF0, pad_oe_n)
		`CHK("out_latch", 8'h05, pad_out & 8'h0F)
		@(posedge aclk) ovr[1].pullup_override_enable <= 1'h1;
		ovr[1].pullup_override_value <= 1'h1;
		ovr[1].direction_override_enable <= 1'h1;
		ovr[4].direction_override_enable <= 1'h1;
		ovr[4].direction_override_value <= 1'h1;
		ovr[0].outvalue_override_enable <= 1'h1;
		@(negedge aclk);
		`CHK("oe_ovr", 8'hE2, pad_oe_n)
		`CHK("pu_ovr", 8'h02, pullup_en)
		`CHK("pv_ovr", 2'h0, {pad_out[4], pad_out[0]})
		ovr_nx = '0;
		ovr_nx[2].toggle_override_enable = 1'h1;
		@(posedge aclk) ovr <= ovr_nx;
		@(posedge aclk) ovr <= '0;
		rd(`GPO_OFS_LATCH);
		`CHK("latch_tog", 32'h01, rd_q)
		wr(`GPO_OFS_PIN, 32'h03);
		rd(`GPO_OFS_LATCH);
		`CHK("pin_tog", 32'h02, rd_q)
		// A frozen clock enable must hold off a pending toggle override
		@(posedge aclk) clk_en <= 1'h0;
		ovr[3].toggle_override_enable <= 1'h1;
		repeat (2) @(posedge aclk);
		ovr[3].toggle_override_enable <= 1'h0;
		clk_en <= 1'h1;
		rd(`GPO_OFS_LATCH);
		`CHK("latch_frozen", 32'h02, rd_q)
		@(posedge aclk) ext_val <= 8'hA5;
		wr(`GPO_OFS_LATCH, 32'h0A);
		// One idle slot passes before the read is taken
		rd(`GPO_OFS_PIN);
		`CHK("pin_read", 32'hAA, rd_q)
		`CHK("rresp", `GPO_RESP_OKAY, rresp_q)
		@(posedge aclk) adrv_en <= 8'h40;
		@(negedge aclk);
		`CHK("analog_drv", 3'h0, {pad_oe_n[6], pad_out[6], link[6]})
		@(posedge aclk) adrv_en <= '0;
		ext_val <= 8'hFF;
		wr(8'h1C, 32'hFF);
		`CHK("bresp_unmapped", `GPO_RESP_SLVERR, bresp_q)
		for (int k = 0; k < 8; k++) begin
			wr(`GPO_OFS_DIR, k[2] ? 32'hFF : 32'h0);
			wr(`GPO_OFS_LATCH, k[1] ? 32'hFF : 32'h0);
			wr(`GPO_OFS_CTRL, {31'h0, k[0]});
			`CHK("pu_table", (k == 2) ? 8'hFF : 8'h00, pullup_en)
		end
		`CHK("bresp_ok", `GPO_RESP_OKAY, bresp_q)
		wr(`GPO_OFS_CTRL, 32'h0);
		wr(`GPO_OFS_DIR, 32'h0F);
		// Upper pins float: only the pull-up can hold them high
		@(posedge aclk) ext_en <= 8'h00;
		rd(`GPO_OFS_PIN);
		`CHK("pin_pulled", 32'hFF, rd_q)
		wr(`GPO_OFS_CTRL, 32'h1);
		rd(`GPO_OFS_PIN);
		`CHK("pin_unpulled", 32'h0F, rd_q)
		wr(`GPO_OFS_CTRL, 32'h0);
		@(posedge aclk) aresetn <= 1'h0;
		#1;
		`CHK("pu_in_reset", 8'h00, pullup_en)
		`CHK("oe_in_reset", 8'hFF, pad_oe_n)
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`GPO_OFS_LATCH);
		`CHK("latch_rst", 32'h0, rd_q)
		tally_and_finish();
	end
endmodule
`default_nettype wire
